// File: logic/sog_tx_gen.sv
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - A1 sent as F6h and A2 as 28h unless edited.
// - B1 is BIP-8 over whole previous frame, never user-set.
// - B2 is BIP-8 per STS-1 (24 bits per STS-3), never user-set.
// - H1, H2, H3 always generated internally.
// - K1 and K2 bits 1-5 carry APS; K2 bits 6-8 carry RDI-L.
// - Edited TOH byte copied into every interleaved column; edited A1/A2 only into the editable ones.
// - Only three A1 and three A2 bytes at the boundary are editable.
// - G1 holds REI in bits 1-4, RDI bit 5, reserved 6-7, spare 8.
// - V5 holds BIP-2, REI, RFI, label, RDI in that order.
// - Z7 holds ext label, LO concat, APS 3-4, reserved, data link.
// - Z4 holds APS bits 1-4, spare 5-6, data link 7-8.
// - Short trace messages padded with configurable ASCII character.
// - User patterns of 32 or 2048 bits repeat in payload.
// - PRBS9 to PRBS31, order n repeats after 2^n-1 bits.
// - PRBS output may be inverted.
// - All zeros, all ones and alternating 1:1, 1:3, 1:7.
// - Two-in-eight pattern 01000010 repeating.
// - Preset picks inverted PRBS31, 23 or 15 by container.
// - TCM off, Z5 STS-3c, Z5 STS-1, Z6 VT; sets container.
// - Second port tx copies first port tx settings when following.
// - Receiver mirrors own tx or first port rx; first never follows.
module sog_tx_gen
    import sog_pkg::*;
#(
    parameter int STS_N = 3,
    parameter bit FIRST_PORT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [31:0] p1_tx_cfg_i,
    input wire logic [31:0] p1_rx_cfg_i,
    output logic [31:0] tx_cfg_o,
    output logic [31:0] rx_cfg_o,
    output logic [7:0] tx_data_o,
    output logic tx_sof_o
);
    localparam int SW = (STS_N > 1) ? $clog2(STS_N) : 1;

    typedef struct packed {
        logic [3:0] row;
        logic [6:0] grp;
        logic [SW-1:0] sts;
        logic [3:0] fcnt;
        logic [30:0] lfsr;
        logic [10:0] upos;
        logic [7:0] b1;
        logic [7:0] b1q;
        logic [STS_N-1:0][7:0] b2;
        logic [STS_N-1:0][7:0] b2q;
        logic [STS_N-1:0][7:0] b3;
        logic [STS_N-1:0][7:0] b3q;
        logic [1:0] bip2;
        logic [1:0] bip2q;
        logic [7:0] dat;
        logic sof;
        logic ack;
        logic [31:0] rdat;
        logic [31:0] txc;
        logic [31:0] rxo;
        logic [31:0] ctrl, toh1, toh2, toh3, poh1, poh2, vt, trc, fol, rxc;
        logic [2:0][15:0][7:0] trm;
        logic [63:0][31:0] um;
    } sog_st_t;

    localparam sog_st_t RST_ST = '{lfsr: '1, ctrl: RST_CTRL, toh1: RST_TOH1,
                                   trc: RST_TRC, default: '0};

    sog_st_t r;
    sog_st_t n;

    function automatic logic [38:0] prbs8(input logic [30:0] s, input logic [2:0] o);
        logic [30:0] t;
        logic [7:0] q;
        logic fb;
        t = s;
        q = '0;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            case (o)
                PO_9: fb = t[8] ^ t[4];
                PO_11: fb = t[10] ^ t[8];
                PO_15: fb = t[14] ^ t[13];
                PO_20: fb = t[19] ^ t[2];
                PO_23: fb = t[22] ^ t[17];
                PO_29: fb = t[28] ^ t[26];
                default: fb = t[30] ^ t[27];
            endcase
            t = {t[29:0], fb};
            q = {q[6:0], fb};
        end
        return {q, t};
    endfunction : prbs8

    function automatic logic [31:0] wr(input logic [31:0] o, input logic [31:0] d,
                                       input logic [3:0] s);
        logic [31:0] v;
        v = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v;
    endfunction : wr

    logic [31:0] ecfg;
    logic [7:0] ob;
    logic [7:0] pb;
    logic [7:0] tb0, tb1, tb2;
    logic [7:0] g1b, z4b, v5b, z7b;
    logic [38:0] pr;
    logic [9:0] wa;
    logic hit;
    logic pay;

    always_comb begin
        // Settings copied from the first port while following
        ecfg = (r.fol[0] && !FIRST_PORT) ? p1_tx_cfg_i : r.ctrl;
        // Trace bytes padded past the programmed length
        tb0 = ({1'b0, r.fcnt} < r.trc[4:0]) ? r.trm[0][r.fcnt] : r.trc[31:24];
        tb1 = ({1'b0, r.fcnt} < r.trc[12:8]) ? r.trm[1][r.fcnt] : r.trc[31:24];
        tb2 = ({1'b0, r.fcnt} < r.trc[20:16]) ? r.trm[2][r.fcnt] : r.trc[31:24];
        g1b = {r.poh2[31:28], r.poh2[27], 2'b00, 1'b0};
        z4b = {r.poh2[23:20], 2'b00, r.poh2[17:16]};
        v5b = {r.bip2q, r.vt[0], r.vt[1], r.vt[4:2], r.vt[5]};
        z7b = {r.vt[6], r.vt[7], r.vt[9:8], 3'b000, r.vt[10]};
        pr = prbs8(r.lfsr, ecfg[CF_ORD +: 3]);
        case (ecfg[CF_MODE +: 4])
            PM_USR32: pb = r.um[0][(3 - r.upos[4:3]) * 8 +: 8];
            PM_USR2K: pb = r.um[r.upos[10:5]][(3 - r.upos[4:3]) * 8 +: 8];
            PM_PRBS: pb = pr[38:31] ^ {8{ecfg[CF_INV]}};
            PM_ZERO: pb = 8'h00;
            PM_ONE: pb = 8'hFF;
            PM_ALT11: pb = 8'h55;
            PM_ALT13: pb = 8'h88;
            PM_ALT17: pb = 8'h80;
            PM_2IN8: pb = 8'h42;
            default: pb = 8'h00;
        endcase
        pay = r.grp > 7'(POH_G);
        ob = pb;
        if (r.grp < 7'(TOH_G)) begin
            // Same edited value in every interleaved column; A1 and A2 only in the A_EDIT editable ones
            case (r.row)
                4'd0: begin
                    if (r.grp == 7'd0) begin
                        ob = (int'(r.sts) + A_EDIT >= STS_N) ? r.toh1[31:24] : A1_FIX;
                    end else if (r.grp == 7'd1) begin
                        ob = (int'(r.sts) < A_EDIT) ? r.toh1[23:16] : A2_FIX;
                    end else begin
                        ob = tb0;
                    end
                end
                4'd1: ob = (r.grp == 7'd0) ? ((r.sts == '0) ? r.b1q : 8'h00) :
                           (r.grp == 7'd1) ? r.toh2[31:24] : r.toh2[23:16];
                4'd2: ob = r.toh3[31:24];
                4'd3: ob = (r.grp == 7'd0) ? H1_VAL : (r.grp == 7'd1) ? H2_VAL : H3_VAL;
                4'd4: ob = (r.grp == 7'd0) ? r.b2q[r.sts] :
                           (r.grp == 7'd1) ? r.toh2[15:8] : r.toh2[7:0];
                4'd8: ob = (r.grp == 7'd0) ? r.toh1[15:8] :
                           (r.grp == 7'd1) ? r.toh1[7:0] : r.toh3[15:8];
                default: ob = r.toh3[23:16];
            endcase
        end else if (r.grp == 7'(POH_G)) begin
            case (r.row)
                4'd0: ob = tb1;
                4'd1: ob = r.b3q[r.sts];
                4'd2: ob = r.poh1[31:24];
                4'd3: ob = g1b;
                4'd4: ob = r.poh1[23:16];
                4'd5: ob = r.poh1[15:8];
                4'd6: ob = r.poh1[7:0];
                4'd7: ob = z4b;
                default: ob = r.poh2[15:8];
            endcase
        end

        n = r;
        n.ack = 1'b0;
        n.dat = ob;
        n.sof = (r.row == 4'd0) && (r.grp == 7'd0) && (r.sts == '0);
        n.txc = ecfg;
        // Receiver settings source
        if (FIRST_PORT || r.fol[2:1] == 2'b00) begin
            n.rxo = r.rxc;
        end else if (r.fol[2:1] == 2'b01) begin
            n.rxo = ecfg;
        end else begin
            n.rxo = p1_rx_cfg_i;
        end
        if (pay) begin
            n.upos = r.upos + 11'd8;
            if (ecfg[CF_MODE +: 4] == PM_USR32) begin
                n.upos[10:5] = '0;
            end
            if (ecfg[CF_MODE +: 4] == PM_PRBS) begin
                n.lfsr = pr[30:0];
            end
            n.bip2 = r.bip2 ^ {^{ob[7], ob[5], ob[3], ob[1]}, ^{ob[6], ob[4], ob[2], ob[0]}};
        end
        // Running parity of the frame being sent
        n.b1 = r.b1 ^ ob;
        if (r.row > 4'd2 || r.grp >= 7'(TOH_G)) begin
            n.b2[r.sts] = r.b2[r.sts] ^ ob;
        end
        if (r.grp >= 7'(POH_G)) begin
            n.b3[r.sts] = r.b3[r.sts] ^ ob;
        end
        n.sts = r.sts + 1'b1;
        if (int'(r.sts) == STS_N - 1) begin
            n.sts = '0;
            n.grp = r.grp + 7'd1;
            if (int'(r.grp) == GRPS - 1) begin
                n.grp = '0;
                n.row = r.row + 4'd1;
                if (int'(r.row) == ROWS - 1) begin
                    // Frame end: parity handed to the next frame
                    n.row = '0;
                    n.fcnt = r.fcnt + 4'd1;
                    n.b1q = n.b1;
                    n.b2q = n.b2;
                    n.b3q = n.b3;
                    n.bip2q = n.bip2;
                    n.b1 = '0;
                    n.b2 = '0;
                    n.b3 = '0;
                    n.bip2 = '0;
                end
            end
        end

        hit = cyc_i && stb_i && !r.ack;
        wa = adr_i[11:2];
        n.ack = hit;
        n.rdat = '0;
        if (hit && we_i) begin
            case (wa)
                ADR_CTRL: begin
                    n.ctrl = wr(r.ctrl, dat_i, sel_i);
                    case (n.ctrl[CF_TCM +: 2])
                        TCM_Z5_3C: n.ctrl[CF_CONT +: 3] = CT_C3_3C;
                        TCM_Z5_1: n.ctrl[CF_CONT +: 3] = CT_C3_1;
                        TCM_Z6: n.ctrl[CF_CONT +: 3] = CT_C12;
                        default: ;
                    endcase
                end
                ADR_TOH1: n.toh1 = wr(r.toh1, dat_i, sel_i);
                ADR_TOH2: n.toh2 = wr(r.toh2, dat_i, sel_i);
                ADR_TOH3: n.toh3 = wr(r.toh3, dat_i, sel_i);
                ADR_POH1: n.poh1 = wr(r.poh1, dat_i, sel_i);
                ADR_POH2: n.poh2 = wr(r.poh2, dat_i, sel_i);
                ADR_VT: n.vt = wr(r.vt, dat_i, sel_i);
                ADR_TRC: n.trc = wr(r.trc, dat_i, sel_i);
                ADR_FOL: n.fol = wr(r.fol, dat_i, sel_i);
                ADR_RXC: n.rxc = wr(r.rxc, dat_i, sel_i);
                ADR_PRE: begin
                    n.ctrl[CF_CONT +: 3] = dat_i[2:0];
                    n.ctrl[CF_MODE +: 4] = PM_PRBS;
                    n.ctrl[CF_INV] = 1'b1;
                    if (dat_i[2:0] == CT_C4) begin
                        n.ctrl[CF_ORD +: 3] = (STS_N == OC768_N) ? PO_31 : PO_23;
                    end else if (dat_i[2:0] == CT_C3_3C) begin
                        n.ctrl[CF_ORD +: 3] = PO_23;
                    end else begin
                        n.ctrl[CF_ORD +: 3] = PO_15;
                    end
                end
                default: begin
                    if (wa[9:6] == ADR_TRM[9:6] && wa[3:2] != 2'b11) begin
                        for (int j = 0; j < 4; j++) begin
                            if (sel_i[j]) begin
                                n.trm[wa[3:2]][{wa[1:0], 2'(3 - j)}] = dat_i[j*8 +: 8];
                            end
                        end
                    end else if (wa[9:6] == ADR_UM[9:6]) begin
                        n.um[wa[5:0]] = wr(r.um[wa[5:0]], dat_i, sel_i);
                    end
                end
            endcase
        end else if (hit) begin
            case (wa)
                ADR_CTRL: n.rdat = r.ctrl;
                ADR_TOH1: n.rdat = r.toh1;
                ADR_TOH2: n.rdat = r.toh2;
                ADR_TOH3: n.rdat = r.toh3;
                ADR_POH1: n.rdat = r.poh1;
                ADR_POH2: n.rdat = r.poh2;
                ADR_VT: n.rdat = r.vt;
                ADR_TRC: n.rdat = r.trc;
                ADR_STAT: n.rdat = {4'h0, r.fcnt, tb2, z7b, v5b};
                ADR_FOL: n.rdat = r.fol;
                ADR_RXC: n.rdat = r.rxc;
                default: begin
                    if (wa[9:6] == ADR_UM[9:6]) begin
                        n.rdat = r.um[wa[5:0]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= RST_ST;
        end else begin
            r <= n;
        end
    end

    assign dat_o = r.rdat;
    assign ack_o = r.ack;
    assign tx_data_o = r.dat;
    assign tx_sof_o = r.sof;
    assign tx_cfg_o = r.txc;
    assign rx_cfg_o = r.rxo;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_a1_fixed_run: assert property (
        (r.row == 4'd0 && r.grp == 7'd0 && int'(r.sts) + A_EDIT < STS_N)
        |=> tx_data_o == A1_FIX) else $error("A1 run byte not fixed");
    a_a2_edit_byte: assert property (
        (r.row == 4'd0 && r.grp == 7'd1 && r.sts == '0)
        |=> tx_data_o == $past(r.toh1[23:16])) else $error("A2 byte wrong");
    a_b1_prev_frame: assert property (
        (r.row == 4'd1 && r.grp == 7'd0 && r.sts == '0)
        |=> tx_data_o == $past(r.b1q)) else $error("B1 not previous parity");
    a_b2_per_sts: assert property (
        (r.row == 4'd4 && r.grp == 7'd0)
        |=> tx_data_o == $past(r.b2q[r.sts])) else $error("B2 wrong");
    a_pointer_h1: assert property (
        (r.row == 4'd3 && r.grp == 7'd0) |=> tx_data_o == H1_VAL)
        else $error("H1 not generated");
    a_k2_rdi_byte: assert property (
        (r.row == 4'd4 && r.grp == 7'd2)
        |=> tx_data_o == $past(r.toh2[7:0])) else $error("K2 wrong");
    a_g1_layout: assert property (
        (r.row == 4'd3 && r.grp == 7'(POH_G))
        |=> tx_data_o[2:0] == 3'b000 && tx_data_o[7:3] == $past(r.poh2[31:27]))
        else $error("G1 layout wrong");
    a_ones_payload: assert property (
        (r.grp > 7'(POH_G) && ecfg[CF_MODE +: 4] == PM_ONE)
        |=> tx_data_o == 8'hFF) else $error("All ones pattern wrong");
    a_follow_copy: assert property (
        (r.fol[0] && !FIRST_PORT) |=> tx_cfg_o == $past(p1_tx_cfg_i))
        else $error("Follow copy wrong");
    a_b1_clear_sof: assert property (
        tx_sof_o |-> r.b1 == $past(ob)) else $error("B1 restart wrong");
    a_wb_ack_pulse: assert property (
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o) else $error("Ack not a pulse");
    a_k1_aps_byte: assert property (
        (r.row == 4'd4 && r.grp == 7'd1)
        |=> tx_data_o == $past(r.toh2[15:8])) else $error("K1 wrong");
    a_j0_pad_byte: assert property (
        (r.row == 4'd0 && r.grp == 7'd2 && r.trc[4:0] == 5'd0)
        |=> tx_data_o == $past(r.trc[31:24])) else $error("J0 padding wrong");
    c_follow_tx: cover property (r.fol[0] && !FIRST_PORT);
    c_frame_start: cover property (tx_sof_o);
    c_preset_write: cover property (ack_o && $past(we_i && adr_i[11:2] == ADR_PRE));
    c_prbs_payload: cover property (r.grp > 7'(POH_G) && ecfg[CF_MODE +: 4] == PM_PRBS);
endmodule : sog_tx_gen

// File: logic/sog_pkg.sv
package sog_pkg;
    localparam logic [7:0] A1_FIX = 8'hF6;
    localparam logic [7:0] A2_FIX = 8'h28;
    localparam logic [7:0] H1_VAL = 8'h62;
    localparam logic [7:0] H2_VAL = 8'h0A;
    localparam logic [7:0] H3_VAL = 8'h00;
    localparam int ROWS = 9;
    localparam int GRPS = 90;
    localparam int TOH_G = 3;
    localparam int POH_G = 3;
    localparam int A_EDIT = 3;
    localparam int OC768_N = 768;
    // Word offsets on the Wishbone bus (byte address bits 11:2)
    localparam logic [9:0] ADR_CTRL = 10'h000;
    localparam logic [9:0] ADR_TOH1 = 10'h001;
    localparam logic [9:0] ADR_TOH2 = 10'h002;
    localparam logic [9:0] ADR_TOH3 = 10'h003;
    localparam logic [9:0] ADR_POH1 = 10'h004;
    localparam logic [9:0] ADR_POH2 = 10'h005;
    localparam logic [9:0] ADR_VT = 10'h006;
    localparam logic [9:0] ADR_TRC = 10'h007;
    localparam logic [9:0] ADR_PRE = 10'h008;
    localparam logic [9:0] ADR_STAT = 10'h009;
    localparam logic [9:0] ADR_FOL = 10'h00A;
    localparam logic [9:0] ADR_RXC = 10'h00B;
    localparam logic [9:0] ADR_TRM = 10'h040;
    localparam logic [9:0] ADR_UM = 10'h080;
    // CTRL fields
    localparam int CF_MODE = 0;
    localparam int CF_ORD = 4;
    localparam int CF_INV = 7;
    localparam int CF_TCM = 8;
    localparam int CF_CONT = 10;
    localparam logic [31:0] RST_CTRL = 32'h0000_0006;
    localparam logic [31:0] RST_TOH1 = 32'hF628_0000;
    localparam logic [31:0] RST_TRC = 32'h2000_0000;
    typedef enum logic [3:0] {
        PM_USR32 = 4'b0000, PM_USR2K = 4'b0001, PM_PRBS = 4'b0010,
        PM_ZERO = 4'b0011, PM_ONE = 4'b0100, PM_ALT11 = 4'b0101,
        PM_ALT13 = 4'b0110, PM_ALT17 = 4'b0111, PM_2IN8 = 4'b1000
    } sog_mode_t;
    typedef enum logic [2:0] {
        PO_9 = 3'b000, PO_11 = 3'b001, PO_15 = 3'b010, PO_20 = 3'b011,
        PO_23 = 3'b100, PO_29 = 3'b101, PO_31 = 3'b110
    } sog_ord_t;
    typedef enum logic [1:0] {
        TCM_OFF = 2'b00, TCM_Z5_3C = 2'b01, TCM_Z5_1 = 2'b10, TCM_Z6 = 2'b11
    } sog_tcm_t;
    typedef enum logic [2:0] {
        CT_C4 = 3'b000, CT_C3_3C = 3'b001, CT_C3_1 = 3'b010,
        CT_C12 = 3'b011, CT_C11 = 3'b100
    } sog_cont_t;
endpackage : sog_pkg

// File: sim/sog_line_rx.sv
`timescale 1ns/1ps
module sog_line_rx
    import sog_pkg::*;
#(
    parameter int STS_N = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] data_i,
    input wire logic sof_i,
    input wire logic [15:0] win_i,
    input wire logic [15:0] pos_i,
    output logic [7:0] byte_o,
    output logic [15:0] frames_o,
    output logic [15:0] ones_o,
    output logic [15:0] par_err_o
);
    localparam int RB = GRPS * STS_N;
    localparam int FR = ROWS * RB;
    logic [7:0] cur [FR];
    logic [7:0] last [FR];
    logic [7:0] b2 [STS_N];
    logic [7:0] pb2 [STS_N];
    logic [7:0] b1;
    logic [7:0] pb1;
    int pos;
    int ones;
    int nb;
    int r;
    int g;
    int s;
    assign byte_o = last[pos_i];
    // Frame capture, parity check and payload ones count
    always @(posedge clk_i) begin
        if (rst_i) begin
            frames_o = '0;
            ones_o = '0;
            par_err_o = '0;
            pos = 0;
        end else begin
            if (sof_i) begin
                if (frames_o != 0) begin
                    last = cur;
                    ones_o = ones[15:0];
                    pb1 = b1;
                    pb2 = b2;
                end
                frames_o++;
                pos = 0;
                b1 = '0;
                ones = 0;
                nb = 0;
                foreach (b2[i]) b2[i] = '0;
            end
            if (frames_o != 0 && pos < FR) begin
                r = pos / RB;
                g = (pos % RB) / STS_N;
                s = pos % STS_N;
                cur[pos] = data_i;
                if (frames_o > 1 && pos == RB && data_i !== pb1) par_err_o++;
                if (frames_o > 1 && r == 4 && g == 0 && data_i !== pb2[s]) par_err_o++;
                b1 ^= data_i;
                if (r >= 3 || g >= 3) b2[s] ^= data_i;
                for (int k = 7; k >= 0; k--) begin
                    if (g >= 4 && nb < int'(win_i)) begin
                        ones += int'(data_i[k]);
                        nb++;
                    end
                end
                pos++;
            end
        end
    end
endmodule : sog_line_rx

// File: sim/tb_sog_tx_gen.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_sog_tx_gen;
    import sog_pkg::*;
    localparam int RB = GRPS * 3;
    typedef struct {logic [31:0] ctrl; logic [15:0] win; logic [15:0] ones; logic chk;
        logic [7:0] b;} sog_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [11:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] p1_tx_cfg_i = '0;
    logic [31:0] p1_rx_cfg_i = '0;
    logic [31:0] dat_o, tx_cfg_o, rx_cfg_o, f_tx, f_rx, q;
    logic [7:0] tx_data_o, bt;
    logic ack_o, tx_sof_o;
    logic [15:0] win = 16'h1000;
    logic [15:0] pos = '0;
    logic [15:0] frames, ones, par_err;
    int mismatches = 0;
    int n_compared = 0;
    sog_row_t rows [11] = '{
        '{32'h0000_0000, 16'h1000, 16'h0100, 1'b0, 8'h00},
        '{32'h0000_0001, 16'h4000, 16'h0010, 1'b0, 8'h00},
        '{32'h0000_0002, 16'h0FF8, 16'h0800, 1'b0, 8'h00},
        '{32'h0000_0082, 16'h0FF8, 16'h07F8, 1'b0, 8'h00},
        '{32'h0000_0012, 16'h3FF8, 16'h2000, 1'b0, 8'h00},
        '{32'h0000_0003, 16'h1000, 16'h0000, 1'b1, 8'h00},
        '{32'h0000_0004, 16'h1000, 16'h1000, 1'b1, 8'hFF},
        '{32'h0000_0005, 16'h1000, 16'h0800, 1'b1, 8'h55},
        '{32'h0000_0006, 16'h1000, 16'h0400, 1'b1, 8'h88},
        '{32'h0000_0007, 16'h1000, 16'h0200, 1'b1, 8'h80},
        '{32'h0000_0008, 16'h1000, 16'h0400, 1'b1, 8'h42}};

    sog_tx_gen #(.STS_N(3), .FIRST_PORT(1'b0)) u_sog_tx_gen (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .p1_tx_cfg_i(p1_tx_cfg_i),
        .p1_rx_cfg_i(p1_rx_cfg_i), .tx_cfg_o(tx_cfg_o), .rx_cfg_o(rx_cfg_o),
        .tx_data_o(tx_data_o), .tx_sof_o(tx_sof_o));
    sog_tx_gen #(.STS_N(3), .FIRST_PORT(1'b1)) u_sog_tx_gen_p1 (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(), .ack_o(), .p1_tx_cfg_i(p1_tx_cfg_i),
        .p1_rx_cfg_i(p1_rx_cfg_i), .tx_cfg_o(f_tx), .rx_cfg_o(f_rx),
        .tx_data_o(), .tx_sof_o());
    sog_line_rx #(.STS_N(3)) u_sog_line_rx (.clk_i(clk_i), .rst_i(rst_i),
        .data_i(tx_data_o), .sof_i(tx_sof_o), .win_i(win), .pos_i(pos), .byte_o(bt),
        .frames_o(frames), .ones_o(ones), .par_err_o(par_err));

    always #4 clk_i = ~clk_i;

    task automatic stop_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wb(input logic [9:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {a, 2'b00};
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        `CHK(ack_o, 1'b1)
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic chk_rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(a, 1'b0, 32'h0000_0000);
        `CHK(q & m, e)
    endtask : chk_rd

    task automatic frames_wait(input int k);
        int f0;
        f0 = int'(frames);
        while (int'(frames) < f0 + k) @(posedge clk_i);
        #1;
    endtask : frames_wait

    task automatic chk_b(input int r, input int g, input int s, input logic [7:0] e);
        pos = 16'(r * RB + g * 3 + s);
        #1;
        `CHK(bt, e)
    endtask : chk_b

    initial begin
        repeat (90_000) @(posedge clk_i);
        `CHK(1'b0, 1'b1)
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        `CHK(tx_sof_o, 1'b0)
        rst_i <= 1'b0;
        chk_rd(ADR_CTRL, 32'hFFFF_FFFF, 32'h0000_0006);
        chk_rd(ADR_TOH1, 32'hFFFF_FFFF, 32'hF628_0000);
        chk_rd(ADR_TRC, 32'hFFFF_FFFF, 32'h2000_0000);
        chk_rd(10'h3FF, 32'hFFFF_FFFF, 32'h0000_0000);
        chk_rd(ADR_PRE, 32'hFFFF_FFFF, 32'h0000_0000);
        `CHK(tx_cfg_o, 32'h0000_0006)
        `CHK(rx_cfg_o, 32'h0000_0000)
        frames_wait(2);
        for (int s = 0; s < 3; s++) begin
            chk_b(0, 0, s, A1_FIX);
            chk_b(0, 1, s, A2_FIX);
            chk_b(3, 0, s, H1_VAL);
            chk_b(3, 1, s, H2_VAL);
            chk_b(3, 2, s, H3_VAL);
            chk_b(0, 2, s, 8'h20);
        end
        wb(ADR_TOH1, 1'b1, 32'h1122_3344);
        wb(ADR_TOH2, 1'b1, 32'h5566_7788);
        wb(ADR_POH2, 1'b1, 32'hAF5F_0000);
        wb(ADR_VT, 1'b1, 32'h0000_06AD);
        wb(ADR_TRC, 1'b1, 32'h2A00_0000);
        frames_wait(2);
        for (int s = 0; s < 3; s++) begin
            chk_b(0, 0, s, 8'h11);
            chk_b(8, 0, s, 8'h33);
            chk_b(4, 1, s, 8'h77);
            chk_b(4, 2, s, 8'h88);
            chk_b(3, 0, s, H1_VAL);
        end
        chk_b(3, 3, 0, 8'hA8);
        chk_b(7, 3, 0, 8'h53);
        chk_b(0, 2, 0, 8'h2A);
        chk_rd(ADR_STAT, 32'h0000_FF00, 32'h0000_6100);
        chk_rd(ADR_STAT, 32'h0000_003F, 32'h0000_0027);
        wb(ADR_TOH1, 1'b1, 32'hF628_0000);
        wb(ADR_UM, 1'b1, 32'h8000_0001);
        foreach (rows[i]) begin
            win = rows[i].win;
            wb(ADR_CTRL, 1'b1, rows[i].ctrl);
            frames_wait(2);
            `CHK(ones, rows[i].ones)
            if (rows[i].chk) chk_b(0, 4, 0, rows[i].b);
        end
        `CHK(par_err, 16'h0000)
        for (int c = 0; c < 5; c++) begin
            wb(ADR_PRE, 1'b1, 32'(c));
            chk_rd(ADR_CTRL, 32'h0000_00FF, (c < 2) ? 32'h0000_00C2 : 32'h0000_00A2);
        end
        for (int t = 0; t < 4; t++) begin
            wb(ADR_CTRL, 1'b1, 32'h0000_1002 | 32'(t << 8));
            chk_rd(ADR_CTRL, 32'h0000_1F00, (t == 0) ? 32'h0000_1000 : 32'((t << 10) | (t << 8)));
        end
        p1_tx_cfg_i <= 32'h0000_0004;
        p1_rx_cfg_i <= 32'h1234_5678;
        wb(ADR_RXC, 1'b1, 32'hCAFE_0001);
        wb(ADR_FOL, 1'b1, 32'h0000_0005);
        repeat (3) @(posedge clk_i);
        `CHK(tx_cfg_o, 32'h0000_0004)
        `CHK(rx_cfg_o, 32'h1234_5678)
        `CHK(f_tx, 32'h0000_0F02)
        `CHK(f_rx, 32'hCAFE_0001)
        frames_wait(2);
        chk_b(0, 4, 0, 8'hFF);
        wb(ADR_FOL, 1'b0 | 1'b1, 32'h0000_0002);
        repeat (3) @(posedge clk_i);
        `CHK(rx_cfg_o, 32'h0000_0F02)
        wb(ADR_FOL, 1'b1, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        `CHK(rx_cfg_o, 32'hCAFE_0001)
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK({tx_sof_o, ack_o, tx_data_o}, 10'h000)
        rst_i <= 1'b0;
        chk_rd(ADR_CTRL, 32'hFFFF_FFFF, 32'h0000_0006);
        `CHK(tx_cfg_o, 32'h0000_0006)
        stop_test();
    end
endmodule : tb_sog_tx_gen
